// File: include/sram_port_regs.vh
`ifndef SRAM_PORT_REGS_VH
`define SRAM_PORT_REGS_VH

// array and lane geometry
`define RAM_ADDR_W      4
`define RAM_DEPTH       16
`define DATA_W          32
`define LANES           4
`define LANE_W          8
`define BURST_W         2

// layout of one write buffer entry: {addr, lanes, parity, data}
`define WB_DATA_LSB     0
`define WB_PAR_LSB      32
`define WB_LANE_LSB     36
`define WB_ADDR_LSB     40
`define WB_W            44
`define WB_DEPTH        16

// reset values
`define BURST_CNT_RST   2'h0
`define MODE_RST        1'b1

`endif

// File: hdl/write_buffer_fifo.v
module write_buffer_fifo #(
  parameter WIDTH = 44,
  parameter DEPTH = 16
) (
  input  wire             clock_i,
  input  wire             rst_n_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output reg  [WIDTH-1:0] out_data_o
);

  function integer clog2;
    input integer value;
    integer v;
    begin
      v = value - 1;
      clog2 = 0;
      while (v > 0)
      begin
        clog2 = clog2 + 1;
        v = v >> 1;
      end
    end
  endfunction

  localparam PW = (DEPTH > 1) ? clog2(DEPTH) : 1;

  ////////////////////////////////////////////////////////////////////////////
  // storage plus one output register, so the head is always a flop
  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [PW-1:0]    wr_ptr;
  reg [PW-1:0]    rd_ptr;
  reg [PW:0]      count;
  reg             head_valid;

  wire store_empty = (count == {(PW+1){1'b0}});
  wire store_full  = (count == DEPTH[PW:0]);
  wire head_take   = !head_valid || out_ready_i;
  wire do_pop      = head_take && !store_empty;
  wire do_push     = in_valid_i && !store_full;

  assign in_ready_o  = !store_full;
  assign out_valid_o = head_valid;

  always @(posedge clock_i)
  begin
    if (do_push)
      store[wr_ptr] <= in_data_i;
  end

  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr     <= {PW{1'b0}};
      rd_ptr     <= {PW{1'b0}};
      count      <= {(PW+1){1'b0}};
      head_valid <= 1'b0;
      out_data_o <= {WIDTH{1'b0}};
    end
    else
    begin
      if (do_push)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_pop)
      begin
        rd_ptr     <= rd_ptr + 1'b1;
        out_data_o <= store[rd_ptr];
      end
      if (head_take)
        head_valid <= !store_empty;
      if (do_push && !do_pop)
        count <= count + 1'b1;
      else if (!do_push && do_pop)
        count <= count - 1'b1;
    end
  end

endmodule

// File: hdl/pipelined_sram_port_control.v
`include "sram_port_regs.vh"

// Overview of operation
// [R1] third chip select, active low, sampled each edge, selects with the other two
// [R2] output drive enable low lets data pins drive; high tristates them
// [R3] outputs tristated in write data cycle, first clock after deselect, while deselected
// [R4] clock qualifier high freezes every internal state; here the strap and scan sync flops and the write buffer head load keep running
// [R5] qualifier high does not deselect; current cycle's outputs are held
// [R6] write data on data lanes captured on rising edge
// [R7] read data comes from address captured at preceding edge, one registered stage
// [R8] parity lanes act like data lanes, each written only by its lane select
// [R9] burst strap high interleaved, low linear; floating counts as high
// [R10] system holds burst strap constant during operation
// [R11] scan serial output changes on falling test clock edge
// [R12] scan serial input sampled on rising test clock edge
// [R13] first select active low, second active high, both sampled, combined with third
// [R14] controller drives write strobe low to write; high with select reads
// [R15] active-low lane selects, qualified by write strobe, pick written lanes and parity
// [R16] burst steps low address bits: linear increments with wrap, interleaved xors count
module pipelined_sram_port_control (
  input  wire                     clock_i,
  input  wire                     rst_n_i,
  input  wire                     chip_sel_a_n_i,
  input  wire                     chip_sel_b_i,
  input  wire                     chip_sel_c_n_i,
  input  wire                     clk_qualify_n_i,
  input  wire                     write_n_i,
  input  wire                     adv_load_i,
  input  wire [`RAM_ADDR_W-1:0]   addr_i,
  input  wire [`LANES-1:0]        lane_write_sel_n_i,
  input  wire                     out_en_n_i,
  input  wire [`DATA_W-1:0]       data_i,
  output reg  [`DATA_W-1:0]       data_o,
  output wire                     data_oe_o,
  input  wire [`LANES-1:0]        parity_lanes_i,
  output reg  [`LANES-1:0]        parity_lanes_o,
  output wire                     parity_lanes_oe_o,
  input  wire                     burst_mode_i,
  output wire                     write_buffer_ready_o,
  input  wire                     tck_i,
  input  wire                     tdi_i,
  output reg                      tdo_o
);

  ////////////////////////////////////////////////////////////////////////////
  // burst address step, used only by advance; load takes addr_i unchanged
  function [`BURST_W-1:0] burst_step;
    input [`BURST_W-1:0] start;
    input [`BURST_W-1:0] beat;
    input                interleaved;
    begin
      if (interleaved)
        burst_step = start ^ beat; // see [R16]
      else
        burst_step = start + beat; // see [R16]
    end
  endfunction

  // byte merge of a lane-masked write over older contents
  function [`DATA_W+`LANES-1:0] lane_merge;
    input [`DATA_W+`LANES-1:0] old_word;
    input [`DATA_W+`LANES-1:0] new_word;
    input [`LANES-1:0]         lanes;
    integer k;
    begin
      lane_merge = old_word;
      for (k = 0; k < `LANES; k = k + 1)
      begin
        if (lanes[k])
        begin
          lane_merge[k*`LANE_W +: `LANE_W] = new_word[k*`LANE_W +: `LANE_W];
          lane_merge[`DATA_W + k]          = new_word[`DATA_W + k]; // see [R8]
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // strap and scan pins cross in through three flops
  reg [2:0] mode_sync;
  reg [2:0] tck_sync;
  reg [2:0] tdi_sync;
  reg       burst_mode;
  reg       scan_bit;

  wire tck_rise = tck_sync[1] && !tck_sync[2];
  wire tck_fall = !tck_sync[1] && tck_sync[2];

  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_sync  <= {3{`MODE_RST}};
      tck_sync   <= 3'h0;
      tdi_sync   <= 3'h0;
      burst_mode <= `MODE_RST;
      scan_bit   <= 1'b0;
      tdo_o      <= 1'b0;
    end
    else
    begin
      mode_sync <= {mode_sync[1:0], burst_mode_i};
      tck_sync  <= {tck_sync[1:0], tck_i};
      tdi_sync  <= {tdi_sync[1:0], tdi_i};
      // strap assumed static, so only a settled level is taken
      if (mode_sync[1] == mode_sync[2])
        burst_mode <= mode_sync[2]; // see [R9]
      if (tck_rise)
        scan_bit <= tdi_sync[2]; // see [R12]
      if (tck_fall)
        tdo_o <= scan_bit; // see [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address stage
  wire selected = !chip_sel_a_n_i && chip_sel_b_i && !chip_sel_c_n_i; // see [R1] [R13]
  wire active   = !clk_qualify_n_i; // see [R4] [R5]

  reg [`RAM_ADDR_W-1:0] burst_base;
  reg [`BURST_W-1:0]    burst_cnt;
  reg                   burst_live;
  reg                   burst_write;
  reg                   s1_valid;
  reg                   s1_write;
  reg [`RAM_ADDR_W-1:0] s1_addr;
  reg [`LANES-1:0]      s1_lanes;
  reg                   drive;

  wire [`BURST_W-1:0] next_beat = burst_cnt + 1'b1;
  wire [`BURST_W-1:0] next_low  = burst_step(burst_base[`BURST_W-1:0], next_beat, burst_mode);

  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      burst_base  <= {`RAM_ADDR_W{1'b0}};
      burst_cnt   <= `BURST_CNT_RST;
      burst_live  <= 1'b0;
      burst_write <= 1'b0;
      s1_valid    <= 1'b0;
      s1_write    <= 1'b0;
      s1_addr     <= {`RAM_ADDR_W{1'b0}};
      s1_lanes    <= {`LANES{1'b0}};
    end
    else if (active) // see [R4]
    begin
      if (!adv_load_i && selected)
      begin
        burst_base  <= addr_i;
        burst_cnt   <= `BURST_CNT_RST;
        burst_live  <= 1'b1;
        burst_write <= !write_n_i; // see [R14]
        s1_valid    <= 1'b1;
        s1_write    <= !write_n_i;
        s1_addr     <= addr_i;
        s1_lanes    <= write_n_i ? {`LANES{1'b0}} : ~lane_write_sel_n_i; // see [R15]
      end
      else if (adv_load_i && burst_live)
      begin
        burst_cnt <= next_beat; // see [R16]
        s1_valid  <= 1'b1;
        s1_write  <= burst_write;
        s1_addr   <= {burst_base[`RAM_ADDR_W-1:`BURST_W], next_low};
        s1_lanes  <= burst_write ? ~lane_write_sel_n_i : {`LANES{1'b0}};
      end
      else
      begin
        burst_live <= 1'b0;
        s1_valid   <= 1'b0;
        s1_write   <= 1'b0;
        s1_lanes   <= {`LANES{1'b0}};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data stage: write capture into the buffer, array, read output register
  reg  [`DATA_W+`LANES-1:0] ram [0:`RAM_DEPTH-1];
  wire [`WB_W-1:0]          wb_head;
  wire                      wb_head_valid;
  wire                      wb_push = active && s1_valid && s1_write;
  wire [`WB_W-1:0]          wb_entry = {s1_addr, s1_lanes, parity_lanes_i, data_i};

  // push side only fills while qualified, so drain keeps pace with it
  write_buffer_fifo #(
    .WIDTH (`WB_W),
    .DEPTH (`WB_DEPTH)
  ) u_write_buffer (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (wb_push),
    .in_ready_o  (write_buffer_ready_o),
    .in_data_i   (wb_entry), // see [R6] [R8]
    .out_valid_o (wb_head_valid),
    .out_ready_i (active),
    .out_data_o  (wb_head)
  );

  wire [`RAM_ADDR_W-1:0]    head_addr  = wb_head[`WB_ADDR_LSB +: `RAM_ADDR_W];
  wire [`LANES-1:0]         head_lanes = wb_head[`WB_LANE_LSB +: `LANES];
  wire [`DATA_W+`LANES-1:0] head_word  = wb_head[`WB_DATA_LSB +: `DATA_W+`LANES];
  wire                      head_drain = active && wb_head_valid;

  always @(posedge clock_i)
  begin
    if (head_drain)
      ram[head_addr] <= lane_merge(ram[head_addr], head_word, head_lanes); // see [R15]
  end

  // copy of the entry pushed at the last qualified edge; it still sits
  // behind the head, so a read right after its write needs it as well
  reg  [`WB_W-1:0] recent;
  reg              recent_valid;

  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      recent       <= {`WB_W{1'b0}};
      recent_valid <= 1'b0;
    end
    else if (active) // see [R4]
    begin
      recent_valid <= wb_push;
      if (wb_push)
        recent <= wb_entry;
    end
  end

  // forward not-yet-drained writes, older head first, then the newer entry
  wire [`DATA_W+`LANES-1:0] ram_word  = ram[s1_addr];
  wire                      fwd_hit   = wb_head_valid && (head_addr == s1_addr);
  wire [`DATA_W+`LANES-1:0] head_fwd  = fwd_hit ?
                                        lane_merge(ram_word, head_word, head_lanes) : ram_word;
  wire [`RAM_ADDR_W-1:0]    new_addr  = recent[`WB_ADDR_LSB +: `RAM_ADDR_W];
  wire [`LANES-1:0]         new_lanes = recent[`WB_LANE_LSB +: `LANES];
  wire [`DATA_W+`LANES-1:0] new_word  = recent[`WB_DATA_LSB +: `DATA_W+`LANES];
  wire                      new_hit   = recent_valid && (new_addr == s1_addr);
  wire [`DATA_W+`LANES-1:0] read_word = new_hit ?
                                        lane_merge(head_fwd, new_word, new_lanes) : head_fwd;

  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      data_o         <= {`DATA_W{1'b0}};
      parity_lanes_o <= {`LANES{1'b0}};
      drive          <= 1'b0;
    end
    else if (active) // see [R5]
    begin
      // write data cycles and deselected cycles leave drive low
      drive <= s1_valid && !s1_write; // see [R3]
      if (s1_valid && !s1_write)
      begin
        data_o         <= read_word[`DATA_W-1:0]; // see [R7]
        parity_lanes_o <= read_word[`DATA_W +: `LANES]; // see [R8]
      end
    end
  end

  // a read directly followed by a write gives up its drive cycle to the
  // write data, so the controller should leave a gap between the two
  wire bus_free = drive && !(s1_valid && s1_write); // see [R3]

  assign data_oe_o         = bus_free && !out_en_n_i; // see [R2] [R3]
  assign parity_lanes_oe_o = bus_free && !out_en_n_i; // see [R8]

endmodule

// File: sim/sram_ctrl_model.sv
module sram_ctrl_model (
  input  wire         clock_i,
  output logic        sel_a_n_o,
  output logic        sel_b_o,
  output logic        sel_c_n_o,
  output logic        write_n_o,
  output logic        adv_load_o,
  output logic [3:0]  addr_o,
  output logic [3:0]  lanes_n_o,
  output logic [31:0] data_o,
  output logic [3:0]  parity_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        wq = 1'b0;
  logic [35:0] wd;
  initial
  begin
    {sel_a_n_o, sel_b_o, sel_c_n_o} = 3'h6;
    write_n_o = 1'b1;
    adv_load_o = 1'b0;
    addr_o = 4'h0;
    lanes_n_o = 4'hF;
    {parity_o, data_o} = 36'h0;
  end
  // one bus cycle per call, pins move just after the falling edge
  task issue(input [2:0] s, input w, input v, input [3:0] a, input [35:0] d, input [3:0] l);
    @(negedge clock_i);
    // idle lanes toggle, so a stale word can never pass for fresh data
    {parity_o, data_o} = wq ? wd : ~{parity_o, data_o};
    {sel_a_n_o, sel_b_o, sel_c_n_o} = s;
    write_n_o = !w;
    adv_load_o = v;
    addr_o = a;
    lanes_n_o = l;
    wq = w && !v && s == 3'h2;
    wd = d;
  endtask
endmodule

// File: sim/sram_port_control_asserts.sv
`include "sram_port_regs.vh"
module sram_port_checker (
  input wire               clock_i,
  input wire               rst_n_i,
  input wire               chip_sel_a_n_i,
  input wire               chip_sel_b_i,
  input wire               chip_sel_c_n_i,
  input wire               clk_qualify_n_i,
  input wire               write_n_i,
  input wire               adv_load_i,
  input wire               out_en_n_i,
  input wire [`DATA_W-1:0] data_o,
  input wire               data_oe_o,
  input wire [`LANES-1:0]  parity_lanes_o,
  input wire               parity_lanes_oe_o,
  input wire               tck_i,
  input wire               tdo_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire ld = !clk_qualify_n_i && !adv_load_i;
  wire sel = !chip_sel_a_n_i && chip_sel_b_i && !chip_sel_c_n_i;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////
  property p_pair; data_oe_o == parity_lanes_oe_o; endproperty
  a_pair: assert property (p_pair) else $error("oe pair");
  property p_mask; out_en_n_i |-> !data_oe_o; endproperty
  a_mask: assert property (p_mask) else $error("oe mask");
  property p_desel; ld && !sel ##1 !clk_qualify_n_i |=> !data_oe_o; endproperty
  a_desel: assert property (p_desel) else $error("desel drive");
  property p_wr; ld && sel && !write_n_i ##1 !clk_qualify_n_i |=> !data_oe_o; endproperty
  a_wr: assert property (p_wr) else $error("write drive");
  property p_wdat; ld && sel && !write_n_i |=> !data_oe_o; endproperty
  a_wdat: assert property (p_wdat) else $error("write data drive");
  // a write loaded right behind a read takes the bus in that read's data cycle
  property p_rd; ld && sel && write_n_i ##1 !clk_qualify_n_i && !(ld && sel && !write_n_i)
    |=> out_en_n_i || data_oe_o; endproperty
  a_rd: assert property (p_rd) else $error("read drive");
  property p_frz; clk_qualify_n_i |=> $stable(data_o) && $stable(parity_lanes_o); endproperty
  a_frz: assert property (p_frz) else $error("frozen data");
  property p_hold; clk_qualify_n_i && !out_en_n_i |=> out_en_n_i || $stable(data_oe_o); endproperty
  a_hold: assert property (p_hold) else $error("frozen drive");
  property p_tdo; $changed(tdo_o) |-> !$past(tck_i); endproperty
  a_tdo: assert property (p_tdo) else $error("scan edge");
endmodule
bind pipelined_sram_port_control sram_port_checker u_sram_port_checker (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .chip_sel_a_n_i(chip_sel_a_n_i),
  .chip_sel_b_i(chip_sel_b_i), .chip_sel_c_n_i(chip_sel_c_n_i), .write_n_i(write_n_i),
  .clk_qualify_n_i(clk_qualify_n_i), .adv_load_i(adv_load_i), .out_en_n_i(out_en_n_i),
  .data_o(data_o), .data_oe_o(data_oe_o), .parity_lanes_o(parity_lanes_o),
  .parity_lanes_oe_o(parity_lanes_oe_o), .tck_i(tck_i), .tdo_o(tdo_o)
);

// File: sim/testbench.sv
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] SEL = 3'h2;
  localparam logic [2:0] DES = 3'h6;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        clk_qualify_n_i = 1'b0;
  logic        out_en_n_i = 1'b0;
  logic        burst_mode_i = 1'b1;
  logic        tck_i = 1'b0;
  logic        tdi_i = 1'b0;
  logic [35:0] q;
  logic        oe;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  wire         a_n, b, c_n, wn, adv, dq_oe, dp_oe, tdo, wb_rdy;
  wire [3:0]   addr, ln, dp_m, dp_o;
  wire [31:0]  dq_m, dq_o;
  // shared pins resolve from the port's output enable alone
  wire [31:0]  dq = dq_oe ? dq_o : dq_m;
  wire [3:0]   dp = dp_oe ? dp_o : dp_m;
  sram_ctrl_model u_sram_ctrl_model (
    .clock_i(clock_i), .sel_a_n_o(a_n), .sel_b_o(b), .sel_c_n_o(c_n), .write_n_o(wn),
    .adv_load_o(adv), .addr_o(addr), .lanes_n_o(ln), .data_o(dq_m), .parity_o(dp_m)
  );
  pipelined_sram_port_control u_pipelined_sram_port_control (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .chip_sel_a_n_i(a_n), .chip_sel_b_i(b),
    .chip_sel_c_n_i(c_n), .clk_qualify_n_i(clk_qualify_n_i), .write_n_i(wn),
    .adv_load_i(adv), .addr_i(addr), .lane_write_sel_n_i(ln), .out_en_n_i(out_en_n_i),
    .data_i(dq), .data_o(dq_o), .data_oe_o(dq_oe), .parity_lanes_i(dp),
    .parity_lanes_o(dp_o), .parity_lanes_oe_o(dp_oe), .burst_mode_i(burst_mode_i),
    .write_buffer_ready_o(wb_rdy), .tck_i(tck_i), .tdi_i(tdi_i), .tdo_o(tdo)
  );
  always #20 clock_i = ~clock_i;
  ////////////////////////////////////////////////
  task results;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      results();
    end
  end
  task do_reset(input logic m);
    @(negedge clock_i);
    rst_n_i = 1'b0;
    burst_mode_i = m;
    repeat (20) @(negedge clock_i);
    rst_n_i = 1'b1;
  endtask
  task wr(input [2:0] s, input [3:0] a, input [35:0] d, input [3:0] l);
    u_sram_ctrl_model.issue(s, 1'b1, 1'b0, a, d, l);
    u_sram_ctrl_model.issue(DES, 1'b0, 1'b0, a, d, 4'hF);
  endtask
  task rd(input [2:0] s, input [3:0] a);
    u_sram_ctrl_model.issue(s, 1'b0, 1'b0, a, 36'h0, 4'hF);
    u_sram_ctrl_model.issue(DES, 1'b0, 1'b0, a, 36'h0, 4'hF);
    @(negedge clock_i);
    q = {dp_o, dq_o};
    oe = dq_oe;
  endtask
  ////////////////////////////////////////////////
  task t_lanes;
    wr(SEL, 4'h3, 36'hF_11223344, 4'h0);
    wr(SEL, 4'h3, 36'h0_AABBCCDD, 4'hA);
    wr(SEL, 4'h4, 36'h5_0F0F0F0F, 4'h0);
    rd(SEL, 4'h3);
    `CHK(q, 36'hA_11BB33DD);
    rd(SEL, 4'h4);
    `CHK(q, 36'h5_0F0F0F0F);
    $display("lanes test done");
  endtask
  task t_select;
    logic [2:0] bad [3];
    bad = '{3'h6, 3'h0, 3'h3};
    wr(SEL, 4'h5, 36'h5_55555555, 4'h0);
    foreach (bad[i])
    begin
      wr(bad[i], 4'h5, 36'h0, 4'h0);
      rd(bad[i], 4'h5);
      `CHK(oe, 1'b0);
    end
    rd(SEL, 4'h5);
    `CHK(q, 36'h5_55555555);
    $display("select test done");
  endtask
  task t_oe;
    out_en_n_i = 1'b1;
    rd(SEL, 4'h4);
    `CHK(oe, 1'b0);
    out_en_n_i = 1'b0;
    rd(SEL, 4'h4);
    `CHK(oe, 1'b1);
    wr(SEL, 4'h6, 36'h0, 4'h0);
    @(negedge clock_i);
    `CHK(dq_oe, 1'b0);
    $display("output enable test done");
  endtask
  // read, write, read back to back: bus turnaround and a read right behind its write
  task t_turn;
    u_sram_ctrl_model.issue(SEL, 1'b0, 1'b0, 4'h4, 36'h0, 4'hF);
    u_sram_ctrl_model.issue(SEL, 1'b1, 1'b0, 4'h7, 36'h9_12345678, 4'h0);
    u_sram_ctrl_model.issue(SEL, 1'b0, 1'b0, 4'h7, 36'h0, 4'hF);
    `CHK(dq_oe, 1'b0);
    u_sram_ctrl_model.issue(DES, 1'b0, 1'b0, 4'h7, 36'h0, 4'hF);
    @(negedge clock_i);
    `CHK({dp_o, dq_o}, 36'h9_12345678);
    `CHK(dq_oe, 1'b1);
    `CHK(wb_rdy, 1'b1);
    $display("turnaround test done");
  endtask
  task t_freeze;
    rd(SEL, 4'h3);
    clk_qualify_n_i = 1'b1;
    repeat (3) @(negedge clock_i);
    `CHK({dp_o, dq_o}, q);
    `CHK(dq_oe, 1'b1);
    clk_qualify_n_i = 1'b0;
    @(negedge clock_i);
    `CHK(dq_oe, 1'b0);
    $display("freeze test done");
  endtask
  task t_scan;
    for (int k = 1; k >= 0; k--)
    begin
      tdi_i = k[0];
      repeat (8) @(negedge clock_i);
      tck_i = 1'b1;
      repeat (8) @(negedge clock_i);
      `CHK(tdo, !k[0]);
      tck_i = 1'b0;
      repeat (8) @(negedge clock_i);
      `CHK(tdo, k[0]);
    end
    $display("scan test done");
  endtask
  task t_burst(input logic m);
    do_reset(m);
    for (int i = 0; i < 4; i++)
      wr(SEL, 4'(i), 36'(32'hA0 + i), 4'h0);
    u_sram_ctrl_model.issue(SEL, 1'b0, 1'b0, 4'h1, 36'h0, 4'hF);
    u_sram_ctrl_model.issue(SEL, 1'b0, 1'b1, 4'h1, 36'h0, 4'hF);
    for (int n = 0; n < 4; n++)
    begin
      u_sram_ctrl_model.issue(n < 2 ? SEL : DES, 1'b0, n < 2, 4'h1, 36'h0, 4'hF);
      `CHK(dq_o, 32'(32'hA0 + (m ? 1 ^ n : (1 + n) % 4)));
    end
    $display("burst test done");
  endtask
  initial
  begin
    do_reset(1'b1);
    t_lanes();
    t_select();
    t_oe();
    t_turn();
    t_freeze();
    t_scan();
    t_burst(1'b1);
    t_burst(1'b0);
    results();
  end
endmodule
